// [core/crf_defs.vh]
// constants for the cpu core register file
// ****************************************
// ****************************************
`ifndef CRF_DEFS_VH
`define CRF_DEFS_VH
// register select codes
`define CRF_SEL_D0      4'h0
`define CRF_SEL_D1      4'h1
`define CRF_SEL_D2      4'h2
`define CRF_SEL_D3      4'h3
`define CRF_SEL_A0      4'h4
`define CRF_SEL_A1      4'h5
`define CRF_SEL_FB      4'h6
`define CRF_SEL_SB      4'h7
`define CRF_SEL_USP     4'h8
`define CRF_SEL_ISP     4'h9
`define CRF_SEL_SP      4'hA
`define CRF_SEL_VTB     4'hB
`define CRF_SEL_PC      4'hC
`define CRF_SEL_FLG     4'hD
// write size codes
`define CRF_SZ_WORD     2'h0
`define CRF_SZ_LOW      2'h1
`define CRF_SZ_HIGH     2'h2
`define CRF_SZ_PAIR     2'h3
// flag bit positions
`define CRF_F_CARRY     0
`define CRF_F_DEBUG     1
`define CRF_F_ZERO      2
`define CRF_F_SIGN      3
`define CRF_F_BANK      4
`define CRF_F_OVF       5
`define CRF_F_STACK     7
// reset values
`define CRF_RST_W16     16'h0000
`define CRF_RST_W20     20'h00000
`define CRF_RST_FLG     11'h000
`endif

// [core/crf_regfile.v]
// cpu core register file with flag logic
`timescale 1ns/1ps
`include "crf_defs.vh"
module crf_regfile (
  input  wire        clk_sys,
  input  wire        resetn,
  input  wire [3:0]  wr_sel,
  input  wire [1:0]  wr_size,
  input  wire        wr_en,
  input  wire [31:0] wr_data,
  input  wire [3:0]  rd_sel,
  input  wire [1:0]  rd_size,
  output reg  [31:0] rd_data,
  input  wire        pc_load,
  input  wire [19:0] pc_next,
  input  wire        alu_flag_en,
  input  wire [31:0] alu_result,
  input  wire        alu_wide,
  input  wire        alu_byte,
  input  wire        alu_carry,
  input  wire        alu_ovf,
  output wire [19:0] program_counter,
  output wire [15:0] active_stack_pointer,
  output wire [15:0] frame_base_reg,
  output wire [15:0] static_base_reg,
  output wire [19:0] vector_table_base,
  output wire [31:0] address_pair,
  output wire [10:0] flag_register
);
  // ****************************************
  // storage: two banks of data/address/frame words
  // ****************************************
  reg [15:0] bank_q [0:1][0:6];
  reg [15:0] sb_q;
  reg [15:0] usp_q;
  reg [15:0] isp_q;
  reg [19:0] vtb_q;
  reg [19:0] pc_q;
  reg [10:0] flg_q;
  reg [10:0] flg_d;
  wire       bk;
  wire [2:0] wi;
  wire [2:0] ri;
  wire [2:0] pi;
  wire       res_zero;
  wire       res_neg;
  integer    b;
  integer    k;

  assign bk = flg_q[`CRF_F_BANK];
  assign wi = wr_sel[2:0];
  assign ri = rd_sel[2:0];
  // pair partner: d0->d2, d1->d3, a0->a1
  assign pi = (wi == 3'd4) ? 3'd5 : (wi + 3'd2);

  // ****************************************
  // register writes
  // ****************************************
  // banked file; sequencer writes whole words, bytes or pairs
  always @(posedge clk_sys) begin
    if (!resetn) begin
      for (b = 0; b < 2; b = b + 1) begin
        for (k = 0; k < 7; k = k + 1) begin
          bank_q[b][k] <= `CRF_RST_W16;
        end
      end
      sb_q  <= `CRF_RST_W16;
      usp_q <= `CRF_RST_W16;
      isp_q <= `CRF_RST_W16;
      vtb_q <= `CRF_RST_W20;
    end else if (wr_en && wr_sel < `CRF_SEL_SB) begin
      case (wr_size)
        `CRF_SZ_LOW: begin
          // only first two words split; others ignore byte writes
          if (wi < 3'd2) begin
            bank_q[bk][wi][7:0] <= wr_data[7:0];
          end
        end
        `CRF_SZ_HIGH: begin
          if (wi < 3'd2) begin
            bank_q[bk][wi][15:8] <= wr_data[7:0];
          end
        end
        `CRF_SZ_PAIR: begin
          // low-numbered register forms the low half
          if (wi < 3'd2 || wi == 3'd4) begin
            bank_q[bk][wi] <= wr_data[15:0];
            bank_q[bk][pi] <= wr_data[31:16];
          end
        end
        default: begin
          bank_q[bk][wi] <= wr_data[15:0];
        end
      endcase
    end else if (wr_en) begin
      case (wr_sel)
        `CRF_SEL_SB:  sb_q  <= wr_data[15:0];
        `CRF_SEL_USP: usp_q <= wr_data[15:0];
        `CRF_SEL_ISP: isp_q <= wr_data[15:0];
        `CRF_SEL_SP: begin
          if (flg_q[`CRF_F_STACK]) begin
            usp_q <= wr_data[15:0];
          end else begin
            isp_q <= wr_data[15:0];
          end
        end
        `CRF_SEL_VTB: vtb_q <= wr_data[19:0];
        default: ;
      endcase
    end
  end

  // ****************************************
  // program counter
  // ****************************************
  // a direct write beats the sequencer's next address
  always @(posedge clk_sys) begin
    if (!resetn) begin
      pc_q <= `CRF_RST_W20;
    end else if (wr_en && wr_sel == `CRF_SEL_PC) begin
      pc_q <= wr_data[19:0];
    end else if (pc_load) begin
      pc_q <= pc_next;
    end
  end

  // ****************************************
  // flags
  // ****************************************
  // result tests honour operand width
  assign res_zero = alu_wide ? (alu_result == 32'h0000_0000) :
                    alu_byte ? (alu_result[7:0] == 8'h00) : (alu_result[15:0] == 16'h0000);
  assign res_neg  = alu_wide ? alu_result[31] : alu_byte ? alu_result[7] : alu_result[15];

  // alu update of carry, zero, sign and overflow wins over a same-cycle software write of flags
  always @* begin
    flg_d = flg_q;
    if (wr_en && wr_sel == `CRF_SEL_FLG) begin
      flg_d = wr_data[10:0];  // debug bit stored as written
    end
    if (alu_flag_en) begin
      flg_d[`CRF_F_CARRY] = alu_carry;
      flg_d[`CRF_F_ZERO]  = res_zero;
      flg_d[`CRF_F_SIGN]  = res_neg;
      flg_d[`CRF_F_OVF]   = alu_ovf;
    end
  end

  always @(posedge clk_sys) begin
    if (!resetn) begin
      flg_q <= `CRF_RST_FLG;
    end else begin
      flg_q <= flg_d;
    end
  end

  // ****************************************
  // read port, one cycle latency
  // ****************************************
  always @(posedge clk_sys) begin
    if (!resetn) begin
      rd_data <= 32'h0000_0000;
    end else begin
      case (rd_sel)
        `CRF_SEL_D0, `CRF_SEL_D1, `CRF_SEL_D2, `CRF_SEL_D3,
        `CRF_SEL_A0, `CRF_SEL_A1, `CRF_SEL_FB: begin
          if (rd_size == `CRF_SZ_LOW) begin
            rd_data <= {24'h000000, bank_q[bk][ri][7:0]};
          end else if (rd_size == `CRF_SZ_HIGH) begin
            rd_data <= {24'h000000, bank_q[bk][ri][15:8]};
          end else if (rd_size == `CRF_SZ_PAIR && ri == 3'd4) begin
            rd_data <= {bank_q[bk][5], bank_q[bk][4]};
          end else if (rd_size == `CRF_SZ_PAIR && ri < 3'd2) begin
            rd_data <= {bank_q[bk][ri + 3'd2], bank_q[bk][ri]};
          end else begin
            rd_data <= {16'h0000, bank_q[bk][ri]};
          end
        end
        `CRF_SEL_SB:  rd_data <= {16'h0000, sb_q};
        `CRF_SEL_USP: rd_data <= {16'h0000, usp_q};
        `CRF_SEL_ISP: rd_data <= {16'h0000, isp_q};
        `CRF_SEL_SP:  rd_data <= {16'h0000, active_stack_pointer};
        `CRF_SEL_VTB: rd_data <= {12'h000, vtb_q};
        `CRF_SEL_PC:  rd_data <= {12'h000, pc_q};
        `CRF_SEL_FLG: rd_data <= {21'h000000, flg_q};
        default:      rd_data <= 32'h0000_0000;
      endcase
    end
  end

  // ****************************************
  // direct views for the sequencer
  // ****************************************
  // stack flag high picks the user pointer
  assign active_stack_pointer = flg_q[`CRF_F_STACK] ? usp_q : isp_q;
  assign program_counter      = pc_q;
  assign frame_base_reg       = bank_q[bk][6];
  assign static_base_reg      = sb_q;
  assign vector_table_base    = vtb_q;
  assign address_pair         = {bank_q[bk][5], bank_q[bk][4]};
  assign flag_register        = flg_q;
endmodule // crf_regfile

// [testbench/crf_regfile_chk.sv]
// port assertions for the register file
`timescale 1ns/1ps
module crf_regfile_chk (
  input logic        clk_sys, resetn, wr_en, pc_load, alu_flag_en, alu_wide, alu_byte, alu_carry, alu_ovf,
  input logic [3:0]  wr_sel,
  input logic [1:0]  wr_size,
  input logic [31:0] wr_data, alu_result, address_pair,
  input logic [19:0] pc_next, program_counter,
  input logic [15:0] static_base_reg,
  input logic [10:0] flag_register
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  // whole-word write; byte sizes are taken on d0 and d1 and refused on d2, d3, a0, a1 and fb, other selects ignore size
  wire ww = wr_en && wr_size == 2'h0;
  pc_load_a: assert property (pc_load && !(wr_en && wr_sel == 4'hC) |=> program_counter == $past(pc_next))
    else $error("pc load lost");
  pc_write_a: assert property (ww && wr_sel == 4'hC |=> program_counter == $past(wr_data[19:0]))
    else $error("pc write lost");
  sb_write_a: assert property (ww && wr_sel == 4'h7 |=> static_base_reg == $past(wr_data[15:0]))
    else $error("static base write lost");
  addr_pair_a: assert property (wr_en && wr_size == 2'h3 && wr_sel == 4'h4 |=> address_pair == $past(wr_data))
    else $error("address pair wrong");
  flag_write_a: assert property (ww && wr_sel == 4'hD && !alu_flag_en |=> flag_register == $past(wr_data[10:0]))
    else $error("flag write lost");
  carry_a: assert property (alu_flag_en |=> flag_register[0] == $past(alu_carry))
    else $error("carry flag wrong");
  ovf_a: assert property (alu_flag_en |=> flag_register[5] == $past(alu_ovf))
    else $error("overflow flag wrong");
  zero_a: assert property (alu_flag_en && alu_wide && !alu_byte |=> flag_register[2] == ($past(alu_result) == 32'h0))
    else $error("zero flag wrong");
  sign_a: assert property (alu_flag_en && !alu_wide && !alu_byte |=> flag_register[3] == $past(alu_result[15]))
    else $error("sign flag wrong");
endmodule // crf_regfile_chk
bind crf_regfile crf_regfile_chk chk_i (.*);

// [testbench/crf_regfile_tb.sv]
// self-checking bench for the register file
`timescale 1ns/1ps
module crf_regfile_tb;
  reg         clk_sys, resetn, wr_en, pc_load, alu_flag_en, alu_wide, alu_byte, alu_carry, alu_ovf;
  reg  [3:0]  wr_sel, rd_sel;
  reg  [1:0]  wr_size, rd_size;
  reg  [31:0] wr_data, alu_result, v, x;
  reg  [19:0] pc_next;
  wire [31:0] rd_data, address_pair;
  wire [19:0] program_counter, vector_table_base;
  wire [15:0] active_stack_pointer, frame_base_reg, static_base_reg;
  wire [10:0] flag_register;
  integer     n_mismatch = 0, n_tests = 0, i, m;
  crf_regfile uut (.clk_sys, .resetn, .wr_sel, .wr_size, .wr_en, .wr_data, .rd_sel, .rd_size, .rd_data,
    .pc_load, .pc_next, .alu_flag_en, .alu_result, .alu_wide, .alu_byte, .alu_carry, .alu_ovf,
    .program_counter, .active_stack_pointer, .frame_base_reg, .static_base_reg, .vector_table_base,
    .address_pair, .flag_register);
  // width seen on read for each select
  function [31:0] wm(input [3:0] s);
    wm = (s == 4'hB || s == 4'hC) ? 32'hFFFFF : s == 4'hD ? 32'h7FF : 32'hFFFF;
  endfunction
  // expected {O,S,Z,C}; md 0 word, 1 byte, 2 long
  function [31:0] fx(input [31:0] r, input [1:0] md, input c, o);
    fx = {o, md[1] ? r[31] : md[0] ? r[7] : r[15], (md[1] ? r : md[0] ? r[7:0] : r[15:0]) == 32'h0, c};
  endfunction
  task chk(input [63:0] nm, input [31:0] got, exp);
    begin
      n_tests = n_tests + 1;
      if (got !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("[FAIL] %0s exp %h got %h", nm, exp, got);
      end
    end
  endtask
  // one-cycle write; the trailing #1 lets outputs settle
  task wr(input [3:0] s, input [1:0] z, input [31:0] d);
    begin
      @(posedge clk_sys);
      wr_en <= 1'b1;
      wr_sel <= s;
      wr_size <= z;
      wr_data <= d;
      @(posedge clk_sys);
      wr_en <= 1'b0;
      #1;
    end
  endtask
  // read data stands from the cycle after the select
  task rd(input [3:0] s, input [1:0] z);
    begin
      @(posedge clk_sys);
      rd_sel <= s;
      rd_size <= z;
      @(posedge clk_sys);
      #1 v = rd_data;
    end
  endtask
  task give_verdict;
    begin
      if (n_mismatch == 0 && n_tests > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
    end
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // tests need under 600 cycles; allow ten times that
  initial begin
    #60000;
    n_mismatch = n_mismatch + 1;
    give_verdict;
  end
  initial begin
    {resetn, wr_en, pc_load, alu_flag_en, alu_wide, alu_byte, alu_carry, alu_ovf} = 8'h0;
    {wr_sel, rd_sel, wr_size, rd_size, wr_data, alu_result, pc_next} = 0;
    m = $urandom(77);
    repeat (5) @(posedge clk_sys);
    resetn <= 1'b1;
    // reset values, then whole-word write and read back
    for (i = 0; i < 14; i = i + 1) begin
      rd(i, 2'h0);
      chk("rst", v & wm(i), 32'h0);
    end
    for (i = 0; i < 13; i = i + 1) begin
      x = $urandom;
      wr(i, 2'h0, x);
      rd(i, 2'h0);
      if (i != 10) chk("word", v & wm(i), x & wm(i));
      if (i == 6) chk("fb", frame_base_reg, x & 32'hFFFF);
      if (i == 7) chk("sb", static_base_reg, x & 32'hFFFF);
      if (i == 11) chk("vtb", vector_table_base, x & 32'hFFFFF);
    end
    // byte halves keep their neighbour
    for (i = 0; i < 2; i = i + 1) begin
      x = $urandom;
      wr(i, 2'h0, x);
      wr(i, 2'h1, 32'hFF);
      rd(i, 2'h0);
      chk("lo", v & 32'hFFFF, {x[15:8], 8'hFF});
      wr(i, 2'h2, 32'h0);
      rd(i, 2'h0);
      chk("hi", v & 32'hFFFF, 32'hFF);
    end
    // pairs, with a refused byte write to the upper word
    for (i = 0; i < 2; i = i + 1) begin
      x = $urandom;
      wr(i, 2'h3, x);
      wr(i + 2, 2'h1, ~x);
      rd(i, 2'h3);
      chk("pair", v, x);
      rd(i + 2, 2'h0);
      chk("upper", v & 32'hFFFF, x >> 16);
    end
    wr(4'h4, 2'h3, x);
    chk("apair", address_pair, x);
    // stack select and bank select; debug bit always written 0
    wr(4'h8, 2'h0, x);
    wr(4'h9, 2'h0, ~x);
    wr(4'h0, 2'h0, x);
    wr(4'hD, 2'h0, 32'h80);
    chk("usp", active_stack_pointer, x & 32'hFFFF);
    wr(4'hD, 2'h0, 32'h10);
    chk("isp", active_stack_pointer, ~x & 32'hFFFF);
    wr(4'h0, 2'h0, ~x);
    rd(4'h0, 2'h0);
    chk("bank1", v & 32'hFFFF, ~x & 32'hFFFF);
    wr(4'hD, 2'h0, 32'h0);
    rd(4'h0, 2'h0);
    chk("bank", v & 32'hFFFF, x & 32'hFFFF);
    // alu flags; first three are width corner cases
    for (i = 0; i < 24; i = i + 1) begin
      m = i < 3 ? i : $urandom % 3;
      @(posedge clk_sys);
      alu_flag_en <= 1'b1;
      alu_result <= i < 3 ? 32'hFFFF0000 : $urandom;
      {alu_wide, alu_byte} <= m[1:0];
      {alu_carry, alu_ovf} <= $urandom;
      @(posedge clk_sys);
      alu_flag_en <= 1'b0;
      #1 x = fx(alu_result, m, alu_carry, alu_ovf);
      chk("alu", {flag_register[5], flag_register[3:2], flag_register[0]}, x);
    end
    @(posedge clk_sys);
    pc_load <= 1'b1;
    pc_next <= $urandom;
    @(posedge clk_sys);
    pc_load <= 1'b0;
    #1 chk("pc", program_counter, pc_next);
    give_verdict;
  end
endmodule // crf_regfile_tb
